// ===== src/prc_consts.vh
// Register map and field constants for the port readback and check block.
// Assumes inclusion by bare name from the design files only.
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH
`define PRC_ADDR_W          4
`define PRC_OFF_READ_CTRL   4'h0
`define PRC_OFF_PUO_LOW     4'h1
`define PRC_OFF_PUO_HIGH    4'h2
`define PRC_OFF_PORT_LATCH  4'h3
`define PRC_OFF_PORT_MODE   4'h4
`define PRC_OFF_PORT_CTRL   4'h5
`define PRC_OFF_PORT_DATA   4'h6
`define PRC_OFF_BIT_OP      4'h7
`define PRC_OFF_CHECK       4'h8
`define PRC_OFF_CHECK_MASK  4'h9
`define PRC_OFF_EDGE_FLAGS  4'hA
`define PRC_OFF_EDGE_CFG    4'hB
`define PRC_OFF_EDGE_FALL   4'hC
`define PRC_BIT_PIN_ACCESS  0
`define PRC_BIT_P9_PULLUP   1
`define PRC_EDGE_EN_RST     7'h00
`define PRC_READ_CTRL_RST   8'h00
`define PRC_PUO_LOW_FIXED   8'h8A
`define PRC_PUO_HIGH_FIXED  8'hFD
`define PRC_PUO_RST         8'h00
`define PRC_MODE_RST        8'hFF
`define PRC_CTRL_RST        8'h00
`define PRC_BITOP_SET       2'h1
`define PRC_BITOP_CLR       2'h2
`define PRC_BITOP_NOT       2'h3
`endif

// ===== src/prc_edge_det.v
// Edge detectors raising external edge interrupt requests from pin levels.
// Assumes pin levels synchronous to the clock; software clears flags.
`timescale 1ns/100ps
module prc_edge_det #(
  parameter N = 7
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Pin levels and edge selection
  input  wire [N-1:0] pin_i,
  input  wire [N-1:0] rise_en_i,
  input  wire [N-1:0] fall_en_i,
  // Flag clear by software
  input  wire [N-1:0] clear_i,
  output reg  [N-1:0] flag_o
);
  reg  [N-1:0] last;
  wire [N-1:0] hit;

  assign hit = (pin_i & ~last & rise_en_i) | (~pin_i & last & fall_en_i);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      last   <= {N{1'b0}};
      flag_o <= {N{1'b0}};
    end else begin
      last   <= pin_i;
      // Timer inputs still flag. A new edge wins over a clear.
      flag_o <= (flag_o & ~clear_i) | hit;
    end
  end
endmodule // prc_edge_det

// ===== src/prc_pin_check.v
// Combinational pin versus latch compare for one 8-bit port.
// Assumes mode bit 1 means input and ctrl bit 1 means control mode.
`timescale 1ns/100ps
module prc_pin_check (
  // Port state
  input  wire [7:0] pin_i,
  input  wire [7:0] latch_i,
  input  wire [7:0] ctrl_out_i,
  input  wire [7:0] mode_in_i,
  input  wire [7:0] ctrl_sel_i,
  input  wire [7:0] has_latch_i,
  // Result
  output wire [7:0] mask_o,
  output wire       mismatch_o
);
  wire [7:0] ref_val;
  wire [7:0] self_cmp;

  // Input or latchless pins compare to themselves.
  assign self_cmp = mode_in_i | ~has_latch_i;
  // Latch or control output as reference.
  assign ref_val  = (self_cmp & pin_i)
                  | (~self_cmp & ((ctrl_sel_i & ctrl_out_i) | (~ctrl_sel_i & latch_i)));
  assign mask_o     = pin_i ^ ref_val;
  assign mismatch_o = |mask_o;
endmodule // prc_pin_check

// ===== src/prc_top.v
// Port readback, pin check, pull-up option and edge request logic.
// Assumes a simple register port with read data one cycle after the strobe.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "prc_consts.vh"
module prc_top #(
  parameter HAS_LATCH = 8'hFF
) (
  // Clock and reset
  input  wire       SYS_CLK_I,
  input  wire       RESET_I,
  // Register port
  input  wire [3:0] ADDR_I,
  input  wire [7:0] WDATA_I,
  input  wire       WR_I,
  input  wire       RD_I,
  output reg  [7:0] RDATA_O,
  // Port pins
  input  wire [7:0] PIN_I,
  output reg  [7:0] PIN_O,
  output reg  [7:0] PIN_OE_O,
  output reg  [7:0] PULLUP_EN_O,
  // Internal control outputs of peripherals sharing the port
  input  wire [7:0] CTRL_OUT_I,
  input  wire [7:0] CTRL_OE_I,
  // Port 9 pins and strobe mode
  input  wire [4:0] P9_INPUT_MODE_I,
  input  wire [4:0] P9_STROBE_MODE_I,
  output reg  [4:0] P9_PULLUP_O,
  // Edge interrupt requests for P21 to P27
  input  wire [6:0] EDGE_PIN_I,
  output reg  [6:0] EDGE_REQ_O
);
  reg  [7:0] port_read_control;
  reg  [7:0] pullup_option_low;
  reg  [7:0] pullup_option_high;
  reg  [7:0] port_latch;
  reg  [7:0] port_mode;
  reg  [7:0] port_ctrl;
  reg  [6:0] rise_en;
  reg  [6:0] fall_en;
  reg  [7:0] next_rdata;
  reg  [7:0] next_latch;
  reg  [7:0] rmw_src;
  reg  [6:0] edge_clear;
  wire [6:0] edge_flag;
  wire [7:0] chk_mask;
  wire       chk_mismatch;
  wire       pin_access_select;
  wire       wr_bitop;
  wire [7:0] bit_sel;

  assign pin_access_select = port_read_control[`PRC_BIT_PIN_ACCESS];
  assign wr_bitop          = WR_I && (ADDR_I == `PRC_OFF_BIT_OP);
  assign bit_sel           = 8'h01 << WDATA_I[2:0];

  // Port read value: latch for outputs, pin for inputs, or pins for all bits with pin_mode set.
  function [7:0] port_value;
    input [7:0] pins;
    input [7:0] latch;
    input [7:0] mode;
    input       pin_mode;
    begin
      port_value = pin_mode ? pins : ((mode & pins) | (~mode & latch));
    end
  endfunction

  prc_pin_check u_check (
    .pin_i       (PIN_I),
    .latch_i     (port_latch),
    .ctrl_out_i  (CTRL_OUT_I),
    .mode_in_i   (port_mode),
    .ctrl_sel_i  (port_ctrl),
    .has_latch_i (HAS_LATCH),
    .mask_o      (chk_mask),
    .mismatch_o  (chk_mismatch)
  );

  prc_edge_det #(.N(7)) u_edge (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RESET_I),
    .pin_i     (EDGE_PIN_I),
    .rise_en_i (rise_en),
    .fall_en_i (fall_en),
    .clear_i   (edge_clear),
    .flag_o    (edge_flag)
  );

  always @* begin
    edge_clear = 7'h00;
    if (WR_I && (ADDR_I == `PRC_OFF_EDGE_FLAGS)) begin
      edge_clear = WDATA_I[6:0];
    end
  end

  // Bit operations: NOT reads the whole port and changes one bit; set and clear work on the latch alone.
  always @* begin
    // Pin access mode takes pins as read value.
    // Normal mode uses latch for output bits.
    rmw_src    = pin_access_select ? PIN_I : port_value(PIN_I, port_latch, port_mode, 1'b0);
    next_latch = port_latch;
    if (WR_I && (ADDR_I == `PRC_OFF_PORT_LATCH)) begin
      next_latch = WDATA_I;
    end else if (wr_bitop) begin
      // Single-bit set and clear touch one latch bit only.
      case (WDATA_I[5:4])
        `PRC_BITOP_SET: next_latch = port_latch | bit_sel;
        `PRC_BITOP_CLR: next_latch = port_latch & ~bit_sel;
        `PRC_BITOP_NOT: next_latch = rmw_src ^ bit_sel;
        default:        next_latch = rmw_src;
      endcase
    end
  end

  always @* begin
    case (ADDR_I)
      `PRC_OFF_READ_CTRL:  next_rdata = {7'h00, pin_access_select};
      `PRC_OFF_PUO_LOW:    next_rdata = pullup_option_low;
      `PRC_OFF_PUO_HIGH:   next_rdata = pullup_option_high;
      `PRC_OFF_PORT_LATCH: next_rdata = port_latch;
      `PRC_OFF_PORT_MODE:  next_rdata = port_mode;
      `PRC_OFF_PORT_CTRL:  next_rdata = port_ctrl;
      // Pin level returned in pin access mode.
      `PRC_OFF_PORT_DATA:  next_rdata = port_value(PIN_I, port_latch, port_mode,
                                                    pin_access_select);
      `PRC_OFF_CHECK:      next_rdata = {7'h00, chk_mismatch};
      `PRC_OFF_CHECK_MASK: next_rdata = chk_mask;
      `PRC_OFF_EDGE_FLAGS: next_rdata = {1'b0, edge_flag};
      `PRC_OFF_EDGE_CFG:   next_rdata = {1'b0, rise_en};
      `PRC_OFF_EDGE_FALL:  next_rdata = {1'b0, fall_en};
      default:             next_rdata = 8'h00;
    endcase
  end

  // Output latch has no reset value.
  always @(posedge SYS_CLK_I) begin
    port_latch <= next_latch;
  end

  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      port_read_control  <= `PRC_READ_CTRL_RST;
      pullup_option_low  <= `PRC_PUO_RST;
      pullup_option_high <= `PRC_PUO_RST;
      port_mode          <= `PRC_MODE_RST;
      port_ctrl          <= `PRC_CTRL_RST;
      rise_en            <= `PRC_EDGE_EN_RST;
      fall_en            <= `PRC_EDGE_EN_RST;
      RDATA_O            <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? next_rdata : 8'h00;
      if (WR_I) begin
        case (ADDR_I)
          `PRC_OFF_READ_CTRL: port_read_control <= {7'h00, WDATA_I[`PRC_BIT_PIN_ACCESS]};
          `PRC_OFF_PUO_LOW:   pullup_option_low  <= WDATA_I & ~`PRC_PUO_LOW_FIXED;
          `PRC_OFF_PUO_HIGH:  pullup_option_high <= WDATA_I & ~`PRC_PUO_HIGH_FIXED;
          `PRC_OFF_PORT_MODE: port_mode <= WDATA_I;
          `PRC_OFF_PORT_CTRL: port_ctrl <= WDATA_I;
          `PRC_OFF_EDGE_CFG:  rise_en   <= WDATA_I[6:0];
          `PRC_OFF_EDGE_FALL: fall_en   <= WDATA_I[6:0];
          default: ;
        endcase
      end
    end
  end

  // Pin drivers and pull-ups, all registered.
  always @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PIN_O       <= 8'h00;
      PIN_OE_O    <= 8'h00;
      PULLUP_EN_O <= 8'h00;
      P9_PULLUP_O <= 5'h00;
      EDGE_REQ_O  <= 7'h00;
    end else begin
      PIN_O       <= (port_ctrl & CTRL_OUT_I) | (~port_ctrl & next_latch);
      PIN_OE_O    <= (port_ctrl & CTRL_OE_I) | (~port_ctrl & ~port_mode);
      PULLUP_EN_O <= pullup_option_low & port_mode & ~port_ctrl;
      // Port 9 pull-ups on input, non-strobe pins.
      P9_PULLUP_O <= {5{pullup_option_high[`PRC_BIT_P9_PULLUP]}} & P9_INPUT_MODE_I
                     & ~P9_STROBE_MODE_I;
      EDGE_REQ_O  <= edge_flag;
    end
  end
endmodule // prc_top

// ===== bench/prc_pin_model.sv
// External circuitry on the eight port pins.
// Assumes the block drives a pin only while its enable is high.
`timescale 1ns/100ps
module prc_pin_model (
  input  wire       clk_i,
  input  wire [7:0] drv_i,
  input  wire [7:0] oe_i,
  input  wire [7:0] pullup_i,
  input  wire [7:0] short_en_i,
  input  wire [7:0] short_val_i,
  output wire [7:0] pin_o
);
  reg [7:0] float_lvl = 8'h00;
  // A floating pin has no defined level, so it flips every cycle.
  always @(posedge clk_i) begin
    float_lvl <= ~float_lvl;
  end
  // A short to a rail beats the block's own drive, as a real fault would.
  assign pin_o = (short_en_i & short_val_i) | (~short_en_i & oe_i & drv_i)
               | (~short_en_i & ~oe_i & (pullup_i | float_lvl));
endmodule // prc_pin_model

// ===== bench/prc_top_properties.sv
// Concurrent checks on the register port and pull-up outputs of prc_top.
// Assumes read data stand one cycle after the strobe and are zero otherwise.
`timescale 1ns/100ps
module prc_top_properties (
  input wire       SYS_CLK_I,
  input wire       RESET_I,
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire       WR_I,
  input wire       RD_I,
  input wire [7:0] RDATA_O,
  input wire [7:0] PIN_OE_O,
  input wire [7:0] PULLUP_EN_O,
  input wire [4:0] P9_INPUT_MODE_I,
  input wire [4:0] P9_STROBE_MODE_I,
  input wire [4:0] P9_PULLUP_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_wr_ctrl; WR_I && !RD_I && ADDR_I == 4'h0; endsequence
  sequence s_rd_ctrl; !WR_I && !RD_I ##1 RD_I && ADDR_I == 4'h0; endsequence
  property p_ctrl_back; s_wr_ctrl ##1 s_rd_ctrl |=> RDATA_O[0] == $past(WDATA_I[0], 3); endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control bit lost");
  property p_ctrl_hi; RD_I && ADDR_I == 4'h0 |=> RDATA_O[7:1] == 7'h00; endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
  property p_pullup_option_low; RD_I && ADDR_I == 4'h1 |=> (RDATA_O & 8'h8A) == 8'h00; endproperty
  a_pullup_option_low: assert property (p_pullup_option_low) else $error("fixed low pull-up bit set");
  property p_pullup_option_high; RD_I && ADDR_I == 4'h2 |=> (RDATA_O & 8'hFD) == 8'h00; endproperty
  a_pullup_option_high: assert property (p_pullup_option_high) else $error("fixed high pull-up bit set");
  property p_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_p9_in; 1'b1 |=> (P9_PULLUP_O & ~$past(P9_INPUT_MODE_I)) == 5'h00; endproperty
  a_p9_in: assert property (p_p9_in) else $error("pull-up on output pin");
  property p_p9_strb; 1'b1 |=> (P9_PULLUP_O & $past(P9_STROBE_MODE_I)) == 5'h00; endproperty
  a_p9_strb: assert property (p_p9_strb) else $error("pull-up on strobe pin");
  property p_rst; disable iff (1'b0) RESET_I ##1 RESET_I |->
    (PIN_OE_O | PULLUP_EN_O) == 8'h00 && P9_PULLUP_O == 5'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pin driven in reset");
endmodule // prc_top_properties
bind prc_top prc_top_properties prc_top_properties_i (
  .SYS_CLK_I        (SYS_CLK_I),
  .RESET_I          (RESET_I),
  .ADDR_I           (ADDR_I),
  .WDATA_I          (WDATA_I),
  .WR_I             (WR_I),
  .RD_I             (RD_I),
  .RDATA_O          (RDATA_O),
  .PIN_OE_O         (PIN_OE_O),
  .PULLUP_EN_O      (PULLUP_EN_O),
  .P9_INPUT_MODE_I  (P9_INPUT_MODE_I),
  .P9_STROBE_MODE_I (P9_STROBE_MODE_I),
  .P9_PULLUP_O      (P9_PULLUP_O)
);

// ===== bench/prc_top_tb_top.sv
// Self-checking bench for prc_top with external pin circuitry attached.
// Assumes the register offsets and field values chosen for the block.
`timescale 1ns/100ps
module prc_top_tb_top;
  reg        SYS_CLK_I = 1'b0;
  reg        RESET_I = 1'b1;
  reg  [3:0] ADDR_I = 4'h0;
  reg  [7:0] WDATA_I = 8'h00;
  reg        WR_I = 1'b0;
  reg        RD_I = 1'b0;
  reg  [7:0] CTRL_OUT_I = 8'h00;
  reg  [7:0] CTRL_OE_I = 8'h00;
  reg  [4:0] P9_INPUT_MODE_I = 5'h00;
  reg  [4:0] P9_STROBE_MODE_I = 5'h00;
  reg  [6:0] EDGE_PIN_I = 7'h00;
  reg  [7:0] short_en = 8'h00;
  wire [7:0] RDATA_O, PIN_I, PIN_O, PIN_OE_O, PULLUP_EN_O;
  wire [4:0] P9_PULLUP_O;
  wire [6:0] EDGE_REQ_O;
  reg  [7:0] d;
  integer    fails = 0;
  integer    num_checks = 0;
  integer    i;
  // Rows hold address, write value and expected read back.
  reg  [23:0] rows [0:4] = '{24'h00FF01, 24'h01FF75, 24'h02FF02, 24'h0DFF00, 24'h000000};
  prc_top prc_top_i (
    .SYS_CLK_I        (SYS_CLK_I),
    .RESET_I          (RESET_I),
    .ADDR_I           (ADDR_I),
    .WDATA_I          (WDATA_I),
    .WR_I             (WR_I),
    .RD_I             (RD_I),
    .RDATA_O          (RDATA_O),
    .PIN_I            (PIN_I),
    .PIN_O            (PIN_O),
    .PIN_OE_O         (PIN_OE_O),
    .PULLUP_EN_O      (PULLUP_EN_O),
    .CTRL_OUT_I       (CTRL_OUT_I),
    .CTRL_OE_I        (CTRL_OE_I),
    .P9_INPUT_MODE_I  (P9_INPUT_MODE_I),
    .P9_STROBE_MODE_I (P9_STROBE_MODE_I),
    .P9_PULLUP_O      (P9_PULLUP_O),
    .EDGE_PIN_I       (EDGE_PIN_I),
    .EDGE_REQ_O       (EDGE_REQ_O)
  );
  prc_pin_model prc_pin_model_i (.clk_i(SYS_CLK_I), .drv_i(PIN_O), .oe_i(PIN_OE_O),
    .pullup_i(PULLUP_EN_O), .short_en_i(short_en), .short_val_i(8'h00), .pin_o(PIN_I));
  always #10 SYS_CLK_I = ~SYS_CLK_I;
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge SYS_CLK_I) begin ADDR_I <= a; WDATA_I <= v; WR_I <= 1'b1; end
    @(posedge SYS_CLK_I) WR_I <= 1'b0;
  endtask
  task rd(input [3:0] a, output [7:0] v);
    @(posedge SYS_CLK_I) begin ADDR_I <= a; RD_I <= 1'b1; end
    @(posedge SYS_CLK_I) RD_I <= 1'b0;
    #1 v = RDATA_O;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK_I);
    #1 chk(PIN_OE_O | PULLUP_EN_O, 8'h00);
    @(posedge SYS_CLK_I) RESET_I <= 1'b0;
    rd(4'h0, d);
    chk(d, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], d);
      chk(d, rows[i][7:0]);
    end
    // All pins are inputs, so the low option shows up as pull-ups.
    chk(PULLUP_EN_O, 8'h75);
    $display("register table done");
    // The latch is written before any output buffer is opened.
    wr(4'h3, 8'h5A);
    wr(4'h4, 8'h00);
    rd(4'h6, d);
    chk(d, 8'h5A);
    chk(PIN_OE_O, 8'hFF);
    chk(PIN_O, 8'h5A);
    @(posedge SYS_CLK_I) short_en <= 8'h02;
    rd(4'h6, d);
    chk(d, 8'h5A);
    rd(4'h8, d);
    chk(d, 8'h01);
    rd(4'h9, d);
    chk(d, 8'h02);
    // Edge enables are all zero here, so no request can land in pin access mode.
    wr(4'h0, 8'h01);
    rd(4'h6, d);
    chk(d, 8'h58);
    // Toggle bit 3 while the shorted pin is read back into the latch.
    wr(4'h7, 8'h33);
    wr(4'h0, 8'h00);
    @(posedge SYS_CLK_I) short_en <= 8'h00;
    rd(4'h3, d);
    chk(d, 8'h50);
    rd(4'h8, d);
    chk(d, 8'h00);
    @(posedge SYS_CLK_I) short_en <= 8'h02;
    // Set bit 1, clear bit 6, then rewrite the byte from the latch in normal mode.
    wr(4'h7, 8'h11);
    wr(4'h7, 8'h26);
    wr(4'h7, 8'h00);
    rd(4'h3, d);
    chk(d, 8'h12);
    wr(4'h4, 8'hFF);
    rd(4'h9, d);
    chk(d, 8'h00);
    $display("pin check done");
    wr(4'hB, 8'h7F);
    wr(4'hC, 8'h7F);
    rd(4'hB, d);
    chk(d, 8'h7F);
    @(posedge SYS_CLK_I) EDGE_PIN_I <= 7'h7F;
    repeat (3) @(posedge SYS_CLK_I);
    #1 chk({1'b0, EDGE_REQ_O}, 8'h7F);
    rd(4'hA, d);
    chk(d, 8'h7F);
    wr(4'hA, 8'h7F);
    repeat (3) @(posedge SYS_CLK_I);
    #1 chk({1'b0, EDGE_REQ_O}, 8'h00);
    @(posedge SYS_CLK_I) EDGE_PIN_I <= 7'h00;
    repeat (3) @(posedge SYS_CLK_I);
    #1 chk({1'b0, EDGE_REQ_O}, 8'h7F);
    wr(4'h2, 8'h02);
    @(posedge SYS_CLK_I) begin
      P9_INPUT_MODE_I  <= 5'h1F;
      P9_STROBE_MODE_I <= 5'h03;
    end
    repeat (2) @(posedge SYS_CLK_I);
    #1 chk({3'h0, P9_PULLUP_O}, 8'h1C);
    wr(4'h2, 8'h00);
    repeat (2) @(posedge SYS_CLK_I);
    #1 chk({3'h0, P9_PULLUP_O}, 8'h00);
    $display("edge and pull-up done");
    wr(4'h0, 8'h01);
    @(posedge SYS_CLK_I) begin
      CTRL_OUT_I <= 8'h0A;
      CTRL_OE_I  <= 8'h0F;
      RESET_I    <= 1'b1;
    end
    repeat (2) @(posedge SYS_CLK_I);
    #1 chk(PIN_OE_O | PULLUP_EN_O, 8'h00);
    @(posedge SYS_CLK_I) RESET_I <= 1'b0;
    rd(4'h0, d);
    chk(d, 8'h00);
    // The latch keeps its value through reset.
    rd(4'h3, d);
    chk(d, 8'h12);
    // Control mode is chosen first, as part of initialisation.
    wr(4'h5, 8'h0F);
    wr(4'h3, 8'h50);
    wr(4'h4, 8'h00);
    rd(4'h9, d);
    chk(d, 8'h02);
    chk(PIN_O, 8'h5A);
    // Control pins go to input mode before the check.
    wr(4'h4, 8'h0F);
    rd(4'h9, d);
    chk(d, 8'h00);
    $display("second reset done");
    report_and_stop;
  end
endmodule // prc_top_tb_top
